// ### hw/motor_cmp_pkg.sv
// Constants, register map and field layouts of the comparator event timing block
package motor_cmp_pkg;

	// ****************************************************************
	// Clock rates and timing counts
	// ****************************************************************
	localparam int unsigned MTC_PERIOD_NS  = 100;
	localparam int unsigned PERIPH_CLK_HZ  = 4_000_000;
	// Start-up filter time, rounded up to whole cycles
	localparam int unsigned STARTUP_NS     = 3000;
	localparam int unsigned STARTUP_CYC    = (STARTUP_NS + MTC_PERIOD_NS - 1) / MTC_PERIOD_NS;
	// One current filter sample period is four peripheral clocks
	localparam int unsigned FILT_PERIODS   = 4;
	localparam int unsigned FILT_TICK_NS   = FILT_PERIODS * (1_000_000_000 / PERIPH_CLK_HZ);
	localparam int unsigned FILT_TICK_CYC  = FILT_TICK_NS / MTC_PERIOD_NS;

	// ****************************************************************
	// Register byte offsets
	// ****************************************************************
	localparam logic [7:0] ADDR_CTRL      = 8'h00;
	localparam logic [7:0] ADDR_STATUS    = 8'h04;
	localparam logic [7:0] ADDR_IRQ_STAT  = 8'h08;
	localparam logic [7:0] ADDR_IRQ_MASK  = 8'h0C;
	localparam logic [7:0] ADDR_ZC_CAP    = 8'h10;
	localparam logic [7:0] ADDR_DEMAG_CAP = 8'h14;
	localparam logic [7:0] ADDR_TACHO_CAP = 8'h18;
	localparam logic [7:0] ADDR_TIMER     = 8'h1C;
	localparam logic [7:0] ADDR_SCF_DIV   = 8'h20;

	// ****************************************************************
	// Field positions and reset values
	// ****************************************************************
	localparam int unsigned STAT_HST_BIT     = 0;
	localparam int unsigned STAT_CL_BIT      = 1;
	localparam int unsigned STAT_STARTUP_BIT = 2;
	localparam logic [23:0] CTRL_RESET       = 24'h000000;
	localparam logic [7:0]  SCF_DIV_RESET    = 8'h05;
	localparam logic [3:0]  IRQ_MASK_RESET   = 4'h0;
	localparam logic [2:0]  REF_SEL_MAX      = 3'h6;

	// ****************************************************************
	// Comparator channel indices
	// ****************************************************************
	localparam int unsigned NUM_CMP   = 4;
	localparam int unsigned CMP_BEMF  = 0;
	localparam int unsigned CMP_DEMAG = 1;
	localparam int unsigned CMP_SENSE = 2;
	localparam int unsigned CMP_CUR   = 3;

	typedef enum logic [1:0] {
		MODE_TACHO,
		MODE_OFF_END,
		MODE_SCF,
		MODE_ON_DELAY
	} sample_mode_t;

	// Sampling configuration register, bits 23:0
	typedef struct packed {
		logic [7:0]   sample_delay_field;
		logic [3:0]   reserved;
		logic         scf_after_delay;
		logic [2:0]   current_filter_count;
		logic [2:0]   ref_threshold_select;
		logic         demag_enable;
		sample_mode_t mode;
		logic         ref_gen_enable;
		logic         cmp_clk_enable;
	} sampling_config_t;

	// Sticky event bits, also the mask layout
	typedef struct packed {
		logic current_limit;
		logic tacho;
		logic demag;
		logic zero_cross;
	} irq_bits_t;

endpackage : motor_cmp_pkg

// ### hw/motor_cmp_timing.sv
// Comparator sampling, capture events and overcurrent shut-off behind a Wishbone slave
//
// The register addresses and the Wishbone register port were left to the implementer.
`timescale 1ns/1ps

module motor_cmp_timing #(
	parameter int unsigned TIMER_W   = 16,
	parameter int unsigned SCF_DIV_W = 8
) (
	input  wire logic                 clk_i,
	input  wire logic                 rst_i,
	input  wire logic                 wb_cyc_i,
	input  wire logic                 wb_stb_i,
	input  wire logic                 wb_we_i,
	input  wire logic [7:0]           wb_adr_i,
	input  wire logic [3:0]           wb_sel_i,
	input  wire logic [31:0]          wb_dat_i,
	output logic      [31:0]          wb_dat_o,
	output logic                      wb_ack_o,
	input  wire logic [motor_cmp_pkg::NUM_CMP-1:0] cmp_i,
	input  wire logic [5:0]           phase_pwm_req_i,
	output logic      [5:0]           phase_pwm_outputs_o,
	output logic                      sensor_state_flag_o,
	output logic                      current_limit_flag_o,
	output logic      [2:0]           ref_threshold_select_o,
	output logic                      cmp_clk_enable_o,
	output logic                      ref_gen_enable_o,
	output logic                      irq_o
);

	// ****************************************************************
	// Elaboration checks
	// ****************************************************************
	if (TIMER_W < 2 || TIMER_W > 32) begin : g_bad_timer
		$error("TIMER_W must lie in 2..32");
	end
	if (SCF_DIV_W < 1 || SCF_DIV_W > 16) begin : g_bad_div
		$error("SCF_DIV_W must lie in 1..16");
	end

	localparam logic [7:0] START_LOAD = 8'(motor_cmp_pkg::STARTUP_CYC);
	localparam logic [3:0] FILT_LOAD  = 4'(motor_cmp_pkg::FILT_TICK_CYC - 1);

	motor_cmp_pkg::sampling_config_t sampling_config_reg;
	motor_cmp_pkg::irq_bits_t        irq_stat_reg;
	motor_cmp_pkg::irq_bits_t        irq_mask_reg;
	motor_cmp_pkg::irq_bits_t        events;
	logic [SCF_DIV_W-1:0]            scf_div_reg;
	logic [TIMER_W-1:0]              motor_timer_count;
	logic [TIMER_W-1:0]              zero_cross_capture_reg;
	logic [TIMER_W-1:0]              demag_capture_reg;
	logic [TIMER_W-1:0]              tacho_capture_reg;
	logic [31:0]                     rdata;
	logic [31:0]                     wr_merged;
	logic                            wb_req;
	logic                            wb_wr;
	logic                            ack_reg;
	logic [31:0]                     dat_reg;

	// ****************************************************************
	// Input synchronisers
	// ****************************************************************
	logic [2:0]                      sync_q [motor_cmp_pkg::NUM_CMP];
	logic [motor_cmp_pkg::NUM_CMP-1:0] lvl_reg;
	logic [motor_cmp_pkg::NUM_CMP-1:0] lvl;

	for (genvar g = 0; g < motor_cmp_pkg::NUM_CMP; g++) begin : g_sync
		always_ff @(posedge clk_i) begin
			if (rst_i) begin
				sync_q[g] <= 3'h0;
			end else begin
				sync_q[g] <= {sync_q[g][1:0], cmp_i[g]};
			end
		end
		// A change counts once stages two and three agree
		always_ff @(posedge clk_i) begin
			if (rst_i) begin
				lvl_reg[g] <= 1'b0;
			end else if (sync_q[g][1] == sync_q[g][2]) begin
				lvl_reg[g] <= sync_q[g][2];
			end
		end
		// edge visible one cycle before the held level
		assign lvl[g] = (sync_q[g][1] == sync_q[g][2]) ? sync_q[g][2] : lvl_reg[g];
	end

	// ****************************************************************
	// Motor timer
	// ****************************************************************
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			motor_timer_count <= '0;
		end else begin
			motor_timer_count <= motor_timer_count + 1'b1;
		end
	end

	// ****************************************************************
	// Start-up filter
	// ****************************************************************
	logic       cmp_en;
	logic       cmp_en_d;
	logic [7:0] start_cnt;
	logic       ready;

	assign cmp_en = sampling_config_reg.cmp_clk_enable | sampling_config_reg.ref_gen_enable;
	// Enable cycle itself counts as start-up, before the counter is loaded
	assign ready  = cmp_en & cmp_en_d & (start_cnt == 8'h00);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cmp_en_d  <= 1'b0;
			start_cnt <= 8'h00;
		end else begin
			cmp_en_d <= cmp_en;
			if (cmp_en && !cmp_en_d) begin
				start_cnt <= START_LOAD;
			end else if (!cmp_en) begin
				start_cnt <= 8'h00;
			end else if (start_cnt != 8'h00) begin
				start_cnt <= start_cnt - 8'h01;
			end
		end
	end

	// ****************************************************************
	// Sampling clock and filter sample tick
	// ****************************************************************
	logic [SCF_DIV_W-1:0] scf_cnt;
	logic                 scf_tick;
	logic [3:0]           filt_cnt;
	logic                 filt_tick;

	assign scf_tick  = (scf_cnt == '0);
	assign filt_tick = (filt_cnt == 4'h0);

	// Divider of zero behaves as one, so the tick never stops
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			scf_cnt <= '0;
		end else if (scf_tick) begin
			scf_cnt <= (scf_div_reg == '0) ? '0 : scf_div_reg - 1'b1;
		end else begin
			scf_cnt <= scf_cnt - 1'b1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			filt_cnt <= FILT_LOAD;
		end else if (filt_tick) begin
			filt_cnt <= FILT_LOAD;
		end else begin
			filt_cnt <= filt_cnt - 4'h1;
		end
	end

	// ****************************************************************
	// PWM on detection and on-time delay
	// ****************************************************************
	logic       pwm_on;
	logic       pwm_on_d;
	logic       on_rise;
	logic [7:0] dly_cnt;
	logic       dly_armed;
	logic       dly_fire;
	logic       win_open;
	logic [7:0] dly_load;

	assign pwm_on   = |phase_pwm_req_i;
	assign on_rise  = pwm_on & ~pwm_on_d;
	assign dly_fire = dly_armed & (dly_cnt == 8'h00) & pwm_on;
	// A zero delay is served as the shortest delay
	assign dly_load = (sampling_config_reg.sample_delay_field == 8'h00) ? 8'h00 :
		sampling_config_reg.sample_delay_field - 8'h01;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pwm_on_d <= 1'b0;
		end else begin
			pwm_on_d <= pwm_on;
		end
	end

	// count the programmed delay from outputs on
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dly_cnt   <= 8'h00;
			dly_armed <= 1'b0;
			win_open  <= 1'b0;
		end else if (!pwm_on) begin
			dly_armed <= 1'b0;
			win_open  <= 1'b0;
		end else if (on_rise) begin
			dly_cnt   <= dly_load;
			dly_armed <= 1'b1;
			win_open  <= 1'b0;
		end else if (dly_fire) begin
			dly_armed <= 1'b0;
			win_open  <= 1'b1;
		end else if (dly_cnt != 8'h00) begin
			dly_cnt <= dly_cnt - 8'h01;
		end
	end

	// ****************************************************************
	// Back-EMF sampling, sensor flag and zero-cross capture
	// ****************************************************************
	logic       bemf_sample;
	logic       zc_now;
	logic       zc_late;
	logic [1:0] zc_pipe;
	logic       hst_reg;
	logic       late_mode;

	assign late_mode = (sampling_config_reg.mode == motor_cmp_pkg::MODE_ON_DELAY) &
		~sampling_config_reg.scf_after_delay;

	always_comb begin
		bemf_sample = 1'b0;
		unique case (sampling_config_reg.mode)
			motor_cmp_pkg::MODE_TACHO: bemf_sample = 1'b0;
			// sample on the edge the outputs turn on
			motor_cmp_pkg::MODE_OFF_END: bemf_sample = on_rise;
			// sample at the sampling clock rate
			motor_cmp_pkg::MODE_SCF: bemf_sample = scf_tick;
			// one sample as the delay runs out, or rate sampling after it when scf_after_delay is set
			motor_cmp_pkg::MODE_ON_DELAY: bemf_sample = sampling_config_reg.scf_after_delay ?
				(win_open & scf_tick & pwm_on) : dly_fire;
		endcase
		bemf_sample = bemf_sample & ready;
	end

	assign zc_now  = bemf_sample & (lvl[motor_cmp_pkg::CMP_BEMF] != hst_reg);
	assign zc_late = zc_pipe[1];

	// sensor flag follows the sampled comparator
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			hst_reg <= 1'b0;
		end else if (bemf_sample) begin
			hst_reg <= lvl[motor_cmp_pkg::CMP_BEMF];
		end
	end

	// two more cycles to the capture
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			zc_pipe <= 2'h0;
		end else begin
			zc_pipe <= {zc_pipe[0], zc_now & late_mode};
		end
	end

	// latch the timer on a zero crossing
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			zero_cross_capture_reg <= '0;
		end else if ((zc_now && !late_mode) || zc_late) begin
			zero_cross_capture_reg <= motor_timer_count;
		end
	end

	// ****************************************************************
	// Demagnetisation and tacho captures
	// ****************************************************************
	logic demag_sample;
	logic demag_ev;
	logic demag_hst;
	logic tacho_ev;

	assign demag_sample = ready & sampling_config_reg.demag_enable & scf_tick;
	assign demag_ev     = demag_sample & (lvl[motor_cmp_pkg::CMP_DEMAG] != demag_hst);
	assign tacho_ev     = ready & (sampling_config_reg.mode == motor_cmp_pkg::MODE_TACHO) &
		(lvl[motor_cmp_pkg::CMP_SENSE] != lvl_reg[motor_cmp_pkg::CMP_SENSE]);

	// demag capture at the rate tick
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			demag_hst         <= 1'b0;
			demag_capture_reg <= '0;
		end else if (demag_sample) begin
			demag_hst <= lvl[motor_cmp_pkg::CMP_DEMAG];
			if (demag_ev) begin
				demag_capture_reg <= motor_timer_count;
			end
		end
	end

	// capture on the sense input edge
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tacho_capture_reg <= '0;
		end else if (tacho_ev) begin
			tacho_capture_reg <= motor_timer_count;
		end
	end

	// ****************************************************************
	// Overcurrent filter and current limit
	// ****************************************************************
	logic       cur_rise;
	logic [2:0] run_cnt;
	logic       cl_set;
	logic       cl_clr;
	logic       cl_reg;
	logic       cl_next;

	assign cur_rise = lvl[motor_cmp_pkg::CMP_CUR] & ~lvl_reg[motor_cmp_pkg::CMP_CUR];

	always_comb begin
		// unfiltered: act on the first rise
		if (sampling_config_reg.current_filter_count == 3'h0) begin
			cl_set = ready & cur_rise;
		// filtered: act on the last qualifying sample
		end else begin
			cl_set = ready & filt_tick & lvl[motor_cmp_pkg::CMP_CUR] &
				(run_cnt == sampling_config_reg.current_filter_count);
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			run_cnt <= 3'h0;
		end else if (!ready) begin
			run_cnt <= 3'h0;
		end else if (filt_tick) begin
			// a clean sample restarts the run
			if (!lvl[motor_cmp_pkg::CMP_CUR] || cl_set) begin
				run_cnt <= 3'h0;
			end else if (run_cnt != 3'h7) begin
				run_cnt <= run_cnt + 3'h1;
			end
		end
	end

	assign cl_clr  = wb_wr & (wb_adr_i == motor_cmp_pkg::ADDR_STATUS) & wb_sel_i[0] &
		wb_dat_i[motor_cmp_pkg::STAT_CL_BIT];
	// set wins over a software clear
	assign cl_next = cl_set | (cl_reg & ~cl_clr);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cl_reg <= 1'b0;
		end else begin
			cl_reg <= cl_next;
		end
	end

	// outputs forced off in the setting cycle
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			phase_pwm_outputs_o <= 6'h00;
		end else begin
			phase_pwm_outputs_o <= cl_next ? 6'h00 : phase_pwm_req_i;
		end
	end

	// ****************************************************************
	// Wishbone slave
	// ****************************************************************
	function automatic logic [31:0] merge_bytes(input logic [31:0] old_v,
		input logic [31:0] new_v, input logic [3:0] sel);
		logic [31:0] res;
		res = old_v;
		for (int b = 0; b < 4; b++) begin
			if (sel[b]) begin
				res[b*8 +: 8] = new_v[b*8 +: 8];
			end
		end
		return res;
	endfunction : merge_bytes

	assign wb_req    = wb_cyc_i & wb_stb_i;
	// Writes act once, in the cycle the ack is raised
	assign wb_wr     = wb_req & wb_we_i & ~ack_reg;
	assign wr_merged = merge_bytes({8'h00, sampling_config_reg}, wb_dat_i, wb_sel_i);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_reg <= 1'b0;
		end else begin
			ack_reg <= wb_req & ~ack_reg;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sampling_config_reg <= motor_cmp_pkg::CTRL_RESET;
		end else if (wb_wr && wb_adr_i == motor_cmp_pkg::ADDR_CTRL) begin
			sampling_config_reg <= wr_merged[23:0];
			// code 111 has no threshold, held at 110
			if (wr_merged[7:5] > motor_cmp_pkg::REF_SEL_MAX) begin
				sampling_config_reg.ref_threshold_select <= motor_cmp_pkg::REF_SEL_MAX;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			scf_div_reg  <= SCF_DIV_W'(motor_cmp_pkg::SCF_DIV_RESET);
			irq_mask_reg <= motor_cmp_pkg::IRQ_MASK_RESET;
		end else if (wb_wr && wb_sel_i[0]) begin
			if (wb_adr_i == motor_cmp_pkg::ADDR_SCF_DIV) begin
				scf_div_reg <= wb_dat_i[SCF_DIV_W-1:0];
			end
			if (wb_adr_i == motor_cmp_pkg::ADDR_IRQ_MASK) begin
				irq_mask_reg <= wb_dat_i[3:0];
			end
		end
	end

	// Events win over a write-one clear in the same cycle
	assign events = '{current_limit: cl_set, tacho: tacho_ev, demag: demag_ev,
		zero_cross: (zc_now & ~late_mode) | zc_late};

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_stat_reg <= '0;
		end else if (wb_wr && wb_sel_i[0] && wb_adr_i == motor_cmp_pkg::ADDR_IRQ_STAT) begin
			irq_stat_reg <= (irq_stat_reg & ~wb_dat_i[3:0]) | events;
		end else begin
			irq_stat_reg <= irq_stat_reg | events;
		end
	end

	always_comb begin
		rdata = 32'h00000000;
		unique case (wb_adr_i)
			motor_cmp_pkg::ADDR_CTRL:      rdata = {8'h00, sampling_config_reg};
			motor_cmp_pkg::ADDR_STATUS: begin
				rdata[motor_cmp_pkg::STAT_HST_BIT]     = hst_reg;
				rdata[motor_cmp_pkg::STAT_CL_BIT]      = cl_reg;
				rdata[motor_cmp_pkg::STAT_STARTUP_BIT] = cmp_en & ~ready;
			end
			motor_cmp_pkg::ADDR_IRQ_STAT:  rdata[3:0] = irq_stat_reg;
			motor_cmp_pkg::ADDR_IRQ_MASK:  rdata[3:0] = irq_mask_reg;
			motor_cmp_pkg::ADDR_ZC_CAP:    rdata[TIMER_W-1:0] = zero_cross_capture_reg;
			motor_cmp_pkg::ADDR_DEMAG_CAP: rdata[TIMER_W-1:0] = demag_capture_reg;
			motor_cmp_pkg::ADDR_TACHO_CAP: rdata[TIMER_W-1:0] = tacho_capture_reg;
			motor_cmp_pkg::ADDR_TIMER:     rdata[TIMER_W-1:0] = motor_timer_count;
			motor_cmp_pkg::ADDR_SCF_DIV:   rdata[SCF_DIV_W-1:0] = scf_div_reg;
			default:                       rdata = 32'h00000000;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dat_reg <= 32'h00000000;
		end else if (wb_req && !ack_reg) begin
			dat_reg <= rdata;
		end
	end

	// ****************************************************************
	// Outputs
	// ****************************************************************
	assign wb_ack_o               = ack_reg;
	assign wb_dat_o               = dat_reg;
	assign sensor_state_flag_o    = hst_reg;
	assign current_limit_flag_o   = cl_reg;
	assign ref_threshold_select_o = sampling_config_reg.ref_threshold_select;
	assign cmp_clk_enable_o       = sampling_config_reg.cmp_clk_enable;
	assign ref_gen_enable_o       = sampling_config_reg.ref_gen_enable;
	assign irq_o                  = |(irq_stat_reg & irq_mask_reg);

endmodule : motor_cmp_timing

// ### sim/motor_cmp_properties.sv
// Port-level timing checks for the comparator event block
`timescale 1ns/1ps
module motor_cmp_properties (
	input wire logic                                clk_i,
	input wire logic                                rst_i,
	input wire logic                                wb_cyc_i,
	input wire logic                                wb_stb_i,
	input wire logic                                wb_we_i,
	input wire logic [7:0]                          wb_adr_i,
	input wire logic [31:0]                         wb_dat_i,
	input wire logic                                wb_ack_o,
	input wire logic [motor_cmp_pkg::NUM_CMP-1:0]   cmp_i,
	input wire logic [5:0]                          phase_pwm_req_i,
	input wire logic [5:0]                          phase_pwm_outputs_o,
	input wire logic                                sensor_state_flag_o,
	input wire logic                                current_limit_flag_o,
	input wire logic [2:0]                          ref_threshold_select_o
);
	// ****
	// Assertions
	// ****
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	logic req;
	logic clr;
	assign req = wb_cyc_i && wb_stb_i;
	// Clear request ignores sel, so the sticky check only gets looser
	assign clr = req && wb_we_i && wb_adr_i == motor_cmp_pkg::ADDR_STATUS && wb_dat_i[1];
	a_ack_reply: assert property (req && !wb_ack_o |=> wb_ack_o)
		else $error("bus request not answered");
	a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	a_ack_idle: assert property (!req |=> !wb_ack_o)
		else $error("ack without request");
	a_pwm_follow: assert property (!current_limit_flag_o && !$past(rst_i)
		|-> phase_pwm_outputs_o == $past(phase_pwm_req_i))
		else $error("phase outputs do not follow request");
	a_limit_off: assert property (current_limit_flag_o |-> phase_pwm_outputs_o == 6'h00)
		else $error("phase outputs on under current limit");
	a_limit_sticky: assert property (current_limit_flag_o && !clr
		|=> current_limit_flag_o)
		else $error("current limit dropped by itself");
	a_limit_cause: assert property ($rose(current_limit_flag_o)
		|-> $past(cmp_i[3], 4))
		else $error("current limit without comparator high");
	a_flag_source: assert property ($changed(sensor_state_flag_o)
		|-> sensor_state_flag_o == $past(cmp_i[0], 4))
		else $error("sensor flag not from comparator level");
	a_ref_legal: assert property (ref_threshold_select_o <= motor_cmp_pkg::REF_SEL_MAX)
		else $error("threshold select out of range");
	c_limit: cover property ($rose(current_limit_flag_o));
	c_flag: cover property ($changed(sensor_state_flag_o));
	c_read: cover property (wb_ack_o && !wb_we_i);
endmodule : motor_cmp_properties

bind motor_cmp_timing motor_cmp_properties chk_u (.*);

// ### sim/motor_cmp_timing_tb_top.sv
// Self-checking bench for the comparator event timing block
`timescale 1ns/1ps
module motor_cmp_timing_tb_top;
	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic        cyc = 1'b0;
	logic        we = 1'b0;
	logic [7:0]  adr = 8'h00;
	logic [31:0] wdat = 32'h0;
	logic [31:0] dat_o;
	logic [31:0] rd;
	logic [31:0] c1;
	logic [3:0]  lvl = 4'h0;
	logic [3:0]  sel = 4'hF;
	logic [3:0]  sm = 4'hF;
	logic [3:0]  cmp;
	logic [5:0]  req = 6'h00;
	logic [5:0]  pwm;
	logic [2:0]  refs;
	logic        ack, sflag, clf, irq, cke, rge;
	int          miscompares = 0, samples_checked = 0, cnt = 0;
	int          nf, ni, no, nc, x, t1, dv;
	logic [7:0]  ra[5] = '{motor_cmp_pkg::ADDR_CTRL, motor_cmp_pkg::ADDR_SCF_DIV,
		motor_cmp_pkg::ADDR_IRQ_MASK, motor_cmp_pkg::ADDR_STATUS, 8'h24};
	logic [31:0] re[5] = '{32'h0, 32'h5, 32'h0, 32'h0, 32'h0};
	always #50 clk_i = ~clk_i;
	always @(posedge clk_i) cnt <= cnt + 1;
	motor_phase_model ph_u (.level_i(lvl), .cmp_o(cmp));
	motor_cmp_timing dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat_o),
		.wb_ack_o(ack), .cmp_i(cmp), .phase_pwm_req_i(req), .phase_pwm_outputs_o(pwm),
		.sensor_state_flag_o(sflag), .current_limit_flag_o(clf), .irq_o(irq),
		.ref_threshold_select_o(refs), .cmp_clk_enable_o(cke), .ref_gen_enable_o(rge));
	// ****
	// Tasks
	// ****
	task automatic test_done;
		if (miscompares == 0 && samples_checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : test_done
	task automatic chk(string n, logic [31:0] e, logic [31:0] g);
		samples_checked++;
		if (g !== e) begin
			miscompares++;
			$display("wrong value %s exp %h got %h", n, e, g);
		end
	endtask : chk
	task automatic chk_lat(string n, int lo, int hi, int g);
		samples_checked++;
		if (g < lo || g > hi) begin
			miscompares++;
			$display("wrong value %s exp %0d..%0d got %0d", n, lo, hi, g);
		end
	endtask : chk_lat
	task automatic wb(logic w, logic [7:0] a, logic [31:0] d);
		@(posedge clk_i);
		cyc <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		sel <= sm;
		do begin
			@(posedge clk_i);
		end while (ack !== 1'b1);
		rd = dat_o;
		cyc <= 1'b0;
	endtask : wb
	// Edges from the last stimulus edge to each event; 99 means never
	task automatic meas(int lim);
		logic f0;
		f0 = sflag;
		{nf, ni, no, nc} = {99, 99, 99, 99};
		for (int n = 1; n <= lim; n++) begin
			@(posedge clk_i);
			#1;
			if (sflag !== f0 && nf == 99) nf = n;
			if (irq === 1'b1 && ni == 99) ni = n;
			if (pwm === 6'h00 && no == 99) no = n;
			if (clf === 1'b1 && nc == 99) nc = n;
		end
	endtask : meas
	function automatic logic [31:0] ctl(int m, int dm, int ff, int ds);
		return 32'(1 + (m << 2) + (dm << 4) + (ff << 8) + (ds << 16));
	endfunction : ctl
	initial begin
		#(100 * 20000);
		miscompares++;
		test_done();
	end
	// ****
	// Scenarios
	// ****
	initial begin
		void'($urandom(32'h215F8A2D));
		repeat (10) @(posedge clk_i);
		rst_i <= 1'b0;
		wb(1'b1, 8'h24, 32'hFFFFFFFF);
		foreach (ra[i]) begin
			wb(1'b0, ra[i], 32'h0);
			chk("reset read", re[i], rd);
		end
		// Mask write without lane 0 is ignored
		sm = 4'h0;
		wb(1'b1, motor_cmp_pkg::ADDR_IRQ_MASK, 32'hF);
		sm = 4'hF;
		wb(1'b0, motor_cmp_pkg::ADDR_IRQ_MASK, 32'h0);
		chk("mask lane", 32'h0, rd);
		for (int k = 0; k < 8; k++) begin
			wb(1'b1, motor_cmp_pkg::ADDR_CTRL, 32'(k << 5));
			chk("ref select", (k == 7) ? 32'h6 : 32'(k), 32'(refs));
		end
		// Start-up window swallows a tacho pulse
		wb(1'b1, motor_cmp_pkg::ADDR_CTRL, ctl(0, 0, 0, 0) | 32'h2);
		chk("enables", 32'h3, {30'h0, rge, cke});
		wb(1'b0, motor_cmp_pkg::ADDR_STATUS, 32'h0);
		chk("startup busy", 32'h4, rd & 32'h4);
		lvl[2] <= 1'b1;
		repeat (5) @(posedge clk_i);
		lvl[2] <= 1'b0;
		repeat (motor_cmp_pkg::STARTUP_CYC) @(posedge clk_i);
		wb(1'b0, motor_cmp_pkg::ADDR_STATUS, 32'h0);
		chk("startup over", 32'h0, rd & 32'h4);
		wb(1'b0, motor_cmp_pkg::ADDR_IRQ_STAT, 32'h0);
		chk("startup events", 32'h0, rd);
		wb(1'b1, motor_cmp_pkg::ADDR_IRQ_MASK, 32'h4);
		@(posedge clk_i);
		t1 = cnt;
		lvl[2] <= 1'b1;
		meas(8);
		chk_lat("tacho irq", 4, 4, ni);
		wb(1'b0, motor_cmp_pkg::ADDR_TACHO_CAP, 32'h0);
		c1 = rd;
		wb(1'b1, motor_cmp_pkg::ADDR_IRQ_STAT, 32'h4);
		chk("irq cleared", 32'h0, 32'(irq));
		wb(1'b1, motor_cmp_pkg::ADDR_IRQ_MASK, 32'h0);
		@(posedge clk_i);
		t1 = cnt - t1;
		lvl[2] <= 1'b0;
		meas(8);
		chk_lat("masked irq", 99, 99, ni);
		wb(1'b0, motor_cmp_pkg::ADDR_TACHO_CAP, 32'h0);
		chk("tacho capture step", 32'(t1), (rd - c1) & 32'hFFFF);
		wb(1'b0, motor_cmp_pkg::ADDR_IRQ_STAT, 32'h0);
		chk("sticky tacho", 32'h4, rd);
		// End of off-time sampling
		wb(1'b1, motor_cmp_pkg::ADDR_IRQ_STAT, 32'hF);
		wb(1'b1, motor_cmp_pkg::ADDR_IRQ_MASK, 32'h1);
		wb(1'b1, motor_cmp_pkg::ADDR_CTRL, ctl(1, 0, 0, 0));
		lvl[0] <= 1'b1;
		repeat (6) @(posedge clk_i);
		x = 1 + $urandom % 63;
		req <= 6'(x);
		meas(6);
		chk_lat("off-end flag", 1, 1, nf);
		chk_lat("off-end capture", 1, 3, ni);
		chk("phase follow", 32'(x), 32'(pwm));
		// On-time sampling after a delay, then with rate sampling
		for (int m = 0; m < 2; m++) begin
			x = 2 + $urandom % 6;
			wb(1'b1, motor_cmp_pkg::ADDR_CTRL, ctl(3, 0, 0, x) | (m << 11));
			req <= 6'h00;
			lvl[0] <= ~lvl[0];
			repeat (6) @(posedge clk_i);
			wb(1'b1, motor_cmp_pkg::ADDR_IRQ_STAT, 32'hF);
			req <= 6'h3F;
			meas(30);
			if (m == 0) chk_lat("delay flag", x + 1, x + 1, nf);
			if (m == 0) chk_lat("delay capture", x + 3, x + 3, ni);
			if (m == 1) chk_lat("delay rate capture", x + 1, x + 5 + 3, ni);
		end
		// Rate sampling and demagnetization
		dv = 3 + $urandom % 4;
		wb(1'b1, motor_cmp_pkg::ADDR_SCF_DIV, 32'(dv));
		wb(1'b1, motor_cmp_pkg::ADDR_CTRL, ctl(2, 1, 0, 0));
		for (int c = 0; c < 2; c++) begin
			wb(1'b1, motor_cmp_pkg::ADDR_IRQ_STAT, 32'hF);
			wb(1'b1, motor_cmp_pkg::ADDR_IRQ_MASK, 32'(1 << c));
			lvl[c] <= ~lvl[c];
			meas(14);
			chk_lat("rate event", 3, dv + 3, ni);
		end
		// Overcurrent, unfiltered, then filtered
		wb(1'b1, motor_cmp_pkg::ADDR_IRQ_MASK, 32'h8);
		lvl[3] <= 1'b1;
		meas(8);
		chk_lat("shut-off", 4, 4, no);
		chk_lat("limit flag", no, no, nc);
		chk_lat("limit irq", no, no, ni);
		lvl[3] <= 1'b0;
		repeat (6) @(posedge clk_i);
		chk("held off", 32'h0, 32'(pwm));
		for (int f = 0; f < 2; f++) begin
			wb(1'b1, motor_cmp_pkg::ADDR_STATUS, 32'h2);
			wb(1'b1, motor_cmp_pkg::ADDR_IRQ_STAT, 32'h8);
			chk("limit cleared", 32'h0, 32'(clf));
			@(posedge clk_i);
			#1;
			chk("phase restored", 32'h3F, 32'(pwm));
			x = (f == 0) ? 1 : 1 + $urandom % 3;
			wb(1'b1, motor_cmp_pkg::ADDR_CTRL, ctl(2, 0, x, 0));
			lvl[3] <= 1'b1;
			if (f == 0) repeat (8) @(posedge clk_i);
			if (f == 0) lvl[3] <= 1'b0;
			meas(60);
			if (f == 0) chk_lat("single sample", 99, 99, nc);
			if (f == 1) chk_lat("filtered limit", 10 * x + 3, 10 * x + 14, nc);
			if (f == 1) chk_lat("filtered off", nc, nc, no);
		end
		// Reset in mid-run
		@(posedge clk_i);
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		#1;
		chk("reset outputs", 32'h0, {pwm, clf, sflag, refs});
		@(posedge clk_i);
		rst_i <= 1'b0;
		wb(1'b0, motor_cmp_pkg::ADDR_CTRL, 32'h0);
		chk("ctrl after reset", 32'h0, rd);
		test_done();
	end
endmodule : motor_cmp_timing_tb_top

// ### sim/motor_phase_model.sv
// Windings and sensors as seen through the analogue comparators
`timescale 1ns/1ps
module motor_phase_model (
	input  wire logic [3:0] level_i,
	output logic      [3:0] cmp_o
);
	// Propagation lands mid-cycle, so comparator edges never meet a clock edge
	initial cmp_o = 4'h0;
	always @(level_i) cmp_o <= #30 level_i;
endmodule : motor_phase_model
